// file: hw/gtas_pkg.sv
// Shared constants for the timing-output and alarm supervisor
package gtas_pkg;
    // Clock and time units
    localparam longint CLK_HZ = 100000000; // System clock rate
    localparam int CLK_PERIOD_NS = 10; // System clock period
    localparam int SEC_CYC = int'(CLK_HZ); // Cycles in one second
    localparam int PULSE_MS = 200; // Second pulse high time
    localparam int PULSE_CYC = PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DELAY_STEP_NS = 100; // Delay resolution, 0.1 us
    localparam int DELAY_STEP_CYC = DELAY_STEP_NS / CLK_PERIOD_NS;
    localparam int DELAY_W = 24; // Holds 0..10,000,000 steps
    localparam int CNT_W = 27; // Cycle and second counters

    // Synthesised clock rates
    localparam longint F_1544K_HZ = 1544000;
    localparam longint F_9600_HZ = 9600;
    localparam longint F_300_HZ = 300;
    localparam longint LOW_PERIOD_US = 30000; // 33.33 Hz period
    localparam longint LOW_PULSE_US = 208; // 33.33 Hz high time
    localparam logic [31:0] NCO_INC_1544K = 32'((F_1544K_HZ << 32) / CLK_HZ);
    localparam logic [31:0] NCO_INC_9600 = 32'((F_9600_HZ << 32) / CLK_HZ);
    localparam logic [31:0] NCO_INC_300 = 32'((F_300_HZ << 32) / CLK_HZ);
    localparam logic [31:0] NCO_INC_33 = 32'((64'h1 << 32) / (LOW_PERIOD_US * CLK_HZ / 1000000));
    localparam logic [31:0] NCO_THR_HALF = 32'h8000_0000;
    localparam logic [31:0] NCO_THR_33 = 32'((LOW_PULSE_US << 32) / LOW_PERIOD_US);

    // Tracking timeout defaults in seconds, used when the limit input is zero
    localparam logic [CNT_W-1:0] AT1_DEFAULT_S = 27'h000_003C; // 1 minute
    localparam logic [CNT_W-1:0] AT2_DEFAULT_S = 27'h000_2328; // 2 h 30 min
    localparam logic [CNT_W-1:0] AT3_DEFAULT_S = 27'h027_8D00; // 30 days

    // Alarm status word layout
    localparam int ST_W = 16;
    localparam int ST_FREQ_ERR = 0;
    localparam int ST_AT2 = 1;
    localparam int ST_AT3 = 2;
    localparam int ST_CPU_FAULT = 3;
    localparam int ST_TEST_MODE = 4;
    localparam int ST_FREE_RUN = 5;
    localparam int ST_SHORT_GATE = 6;
    localparam int ST_OUT_FAULT = 7;
    localparam int ST_OSC_ADJ = 8;
    localparam int ST_AT1 = 9;
    localparam int ST_BATTERY = 10;
    localparam int ST_OFFSET = 11;
    localparam int ST_MAJOR = 12;
    localparam int ST_MINOR = 13;
    localparam int ST_TRACKING = 14;
    localparam int ST_DISCIPLINED = 15;
endpackage

// file: hw/gtas_nco.sv
// Phase-accumulator clock generator, restartable at the second mark
`timescale 1ns/1ps
module gtas_nco (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sync_in,
    input wire logic [31:0] inc_in,
    input wire logic [31:0] thr_in,
    output logic wave_out
);
    logic [31:0] acc_q; // Phase accumulator
    logic [31:0] acc_d; // Next phase, wraps by design
    logic wave_q; // Registered output level

    // Phase below threshold means high; restart puts a leading edge on the mark
    assign acc_d = acc_q + inc_in;
    assign wave_out = wave_q;

    // Accumulate; sync zeroes phase so the rising edge is pinned to the mark
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q <= 32'h0000_0000;
            wave_q <= 1'b0;
        end else if (sync_in) begin
            acc_q <= 32'h0000_0000;
            wave_q <= 1'b1;
        end else begin
            acc_q <= acc_d;
            wave_q <= (acc_d < thr_in);
        end
    end
endmodule

// file: hw/gtas_top.sv
// Timing outputs and alarm supervisor: pulses, clocks, timeouts, lamps, relays
`timescale 1ns/1ps
module gtas_top
    import gtas_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYC, // Shorten in simulation
    parameter int PULSE_CYCLES = PULSE_CYC // Shorten in simulation
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic rx_second_mark_in,
    input wire logic rx_tracking_in,
    input wire logic osc_disciplined_in,
    input wire logic [DELAY_W-1:0] fp_delay_in,
    input wire logic [DELAY_W-1:0] dclk_delay_in,
    input wire logic dclk_low_rate_sel_in,
    input wire logic [CNT_W-1:0] first_tracking_timeout_limit_in,
    input wire logic [CNT_W-1:0] second_tracking_timeout_limit_in,
    input wire logic [CNT_W-1:0] third_tracking_timeout_limit_in,
    input wire logic freq_error_in,
    input wire logic cpu_fault_in,
    input wire logic test_mode_in,
    input wire logic free_run_in,
    input wire logic short_gate_in,
    input wire logic [3:0] output_missing_in,
    input wire logic osc_near_limit_in,
    input wire logic battery_fail_in,
    input wire logic offset_new_in,
    input wire logic offset_settled_in,
    input wire logic suppress_en_in,
    output logic fp_second_pulse_out,
    output logic clk_1544k_out,
    output logic dclk_second_pulse_out,
    output logic dclk_9600_out,
    output logic dclk_low_rate_out,
    output logic dclk_at1_out,
    output logic dclk_at1_oen_out,
    output logic dclk_at2_out,
    output logic dclk_at2_oen_out,
    output logic t1544_at1_relay_out,
    output logic satellite_tracking_lamp_out,
    output logic oscillator_locked_lamp_out,
    output logic major_lamp_out,
    output logic minor_lamp_out,
    output logic major_relay_out,
    output logic minor_relay_out,
    output logic at1_relay_out,
    output logic at2_relay_out,
    output logic at3_relay_out,
    output logic [3:0] freq_out_en_out,
    output logic [ST_W-1:0] alarm_status_out
);
    localparam logic [CNT_W-1:0] SEC_LAST = CNT_W'(SEC_CYCLES - 1); // Wrap point
    localparam logic [CNT_W-1:0] WIDTH_LAST = CNT_W'(PULSE_CYCLES - 1); // Pulse end
    localparam logic [CNT_W-1:0] SEC_LIMIT = CNT_W'(SEC_CYCLES); // Delay ceiling

    // Reset synchroniser; only the second stage is used downstream
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Delay steps to cycles; a full second folds onto the next mark
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [DELAY_W-1:0] steps);
        logic [CNT_W-1:0] cyc;
        cyc = CNT_W'(steps) * CNT_W'(DELAY_STEP_CYC);
        return (cyc >= SEC_LIMIT) ? '0 : cyc;
    endfunction

    // Cycles since the last receiver mark; free-runs while the mark is absent
    logic [CNT_W-1:0] sec_cnt_q;
    logic sec_wrap; // Internal second boundary
    logic sec_tick; // One tick per second for timeouts
    logic sec_start; // First cycle of a new second
    assign sec_wrap = (sec_cnt_q == SEC_LAST);
    assign sec_tick = rx_second_mark_in | sec_wrap;
    assign sec_start = (sec_cnt_q == '0);

    // Counter restarts on the mark so phase follows the receiver
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_q <= '0;
        end else if (sec_tick) begin
            sec_cnt_q <= '0;
        end else begin
            sec_cnt_q <= sec_cnt_q + 1'b1;
        end
    end

    // Two delayed second pulses: index 0 front panel, index 1 data clock
    logic [CNT_W-1:0] dly_cyc [2]; // Programmed delay in cycles
    logic [CNT_W-1:0] width_cnt_q [2]; // High-time counter
    logic [1:0] pulse_q; // Registered pulse levels
    logic [1:0] pulse_fire; // Delay point reached this cycle
    assign dly_cyc[0] = delay_cycles(fp_delay_in);
    assign dly_cyc[1] = delay_cycles(dclk_delay_in);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pulse
            // Fire when cycles since the mark equal the delay; zero delay is 2 cycles late
            assign pulse_fire[g] = (sec_cnt_q == dly_cyc[g]);
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    pulse_q[g] <= 1'b0;
                    width_cnt_q[g] <= '0;
                end else if (pulse_fire[g] && !pulse_q[g]) begin
                    pulse_q[g] <= 1'b1;
                    width_cnt_q[g] <= '0;
                end else if (pulse_q[g]) begin
                    // 200 ms high, which is also the 20 percent data duty
                    pulse_q[g] <= (width_cnt_q[g] != WIDTH_LAST);
                    width_cnt_q[g] <= width_cnt_q[g] + 1'b1;
                end
            end
        end
    endgenerate
    assign fp_second_pulse_out = pulse_q[0];
    assign dclk_second_pulse_out = pulse_q[1];

    // Synthesised clocks; data clocks restart on each second boundary
    logic [31:0] low_inc; // 300 Hz or 33.33 Hz rate
    logic [31:0] low_thr; // Half duty or 208 us pulse
    assign low_inc = dclk_low_rate_sel_in ? NCO_INC_33 : NCO_INC_300;
    assign low_thr = dclk_low_rate_sel_in ? NCO_THR_33 : NCO_THR_HALF;

    // Free-running: duty is 32 or 33 of about 64.8 cycles, inside 48-52 percent
    gtas_nco u_nco_1544k (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .sync_in(1'b0),
        .inc_in(NCO_INC_1544K),
        .thr_in(NCO_THR_HALF),
        .wave_out(clk_1544k_out)
    );
    gtas_nco u_nco_9600 (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .sync_in(sec_start),
        .inc_in(NCO_INC_9600),
        .thr_in(NCO_THR_HALF),
        .wave_out(dclk_9600_out)
    );
    gtas_nco u_nco_low (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .sync_in(sec_start),
        .inc_in(low_inc),
        .thr_in(low_thr),
        .wave_out(dclk_low_rate_out)
    );

    // Tracking timeouts; a zero limit selects the factory default
    logic [CNT_W-1:0] at_lim_in [3]; // Limits from the controller
    logic [CNT_W-1:0] at_dflt [3]; // Factory defaults
    logic [CNT_W-1:0] at_cnt_q [3]; // Seconds without a satellite
    logic [2:0] at_q; // Expired flags
    assign at_lim_in[0] = first_tracking_timeout_limit_in;
    assign at_lim_in[1] = second_tracking_timeout_limit_in;
    assign at_lim_in[2] = third_tracking_timeout_limit_in;
    assign at_dflt[0] = AT1_DEFAULT_S;
    assign at_dflt[1] = AT2_DEFAULT_S;
    assign at_dflt[2] = AT3_DEFAULT_S;

    generate
        for (g = 0; g < 3; g++) begin : g_timeout
            logic [CNT_W-1:0] lim; // Effective limit
            assign lim = (at_lim_in[g] == '0) ? at_dflt[g] : at_lim_in[g];
            // Saturating second count, cleared while tracking
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    at_cnt_q[g] <= '0;
                    at_q[g] <= 1'b0;
                end else begin
                    if (rx_tracking_in) begin
                        at_cnt_q[g] <= '0;
                    end else if (sec_tick && (at_cnt_q[g] != '1)) begin
                        at_cnt_q[g] <= at_cnt_q[g] + 1'b1;
                    end
                    at_q[g] <= !rx_tracking_in && (at_cnt_q[g] >= lim);
                end
            end
        end
    endgenerate

    // Offset alarm: set by a new offset, cleared on correction; set wins
    logic offset_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            offset_q <= 1'b0;
        end else if (offset_new_in) begin
            offset_q <= 1'b1;
        end else if (offset_settled_in) begin
            offset_q <= 1'b0;
        end
    end

    // Fault classification, purely combinational so nothing latches
    logic major_cause;
    logic minor_cause;
    assign major_cause = freq_error_in | at_q[1] | at_q[2] | cpu_fault_in | test_mode_in
        | free_run_in | short_gate_in;
    assign minor_cause = (|output_missing_in) | osc_near_limit_in | at_q[0] | battery_fail_in
        | offset_q | test_mode_in;

    // Status word for the command-port logs
    logic [ST_W-1:0] status_d;
    always_comb begin
        status_d = '0;
        status_d[ST_FREQ_ERR] = freq_error_in;
        status_d[ST_AT2] = at_q[1];
        status_d[ST_AT3] = at_q[2];
        status_d[ST_CPU_FAULT] = cpu_fault_in;
        status_d[ST_TEST_MODE] = test_mode_in;
        status_d[ST_FREE_RUN] = free_run_in;
        status_d[ST_SHORT_GATE] = short_gate_in;
        status_d[ST_OUT_FAULT] = |output_missing_in;
        status_d[ST_OSC_ADJ] = osc_near_limit_in;
        status_d[ST_AT1] = at_q[0];
        status_d[ST_BATTERY] = battery_fail_in;
        status_d[ST_OFFSET] = offset_q;
        status_d[ST_MAJOR] = major_cause;
        status_d[ST_MINOR] = minor_cause;
        status_d[ST_TRACKING] = rx_tracking_in;
        status_d[ST_DISCIPLINED] = osc_disciplined_in;
    end

    // Registered lamps, relays and enables; all follow their causes each cycle
    logic major_q;
    logic minor_q;
    logic trk_lamp_q;
    logic lock_lamp_q;
    logic [2:0] at_relay_q;
    logic [1:0] at_oen_q; // Open-drain release for data-connector status
    logic od_level_q; // Level driven when enabled, always ground
    logic [3:0] fo_en_q;
    logic [ST_W-1:0] status_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            major_q <= 1'b0;
            minor_q <= 1'b0;
            trk_lamp_q <= 1'b0;
            lock_lamp_q <= 1'b0;
            at_relay_q <= 3'h0;
            at_oen_q <= 2'h0;
            od_level_q <= 1'b0;
            fo_en_q <= 4'hF;
            status_q <= '0;
        end else begin
            major_q <= major_cause;
            minor_q <= minor_cause;
            trk_lamp_q <= rx_tracking_in & ~at_q[0];
            lock_lamp_q <= osc_disciplined_in & ~at_q[1];
            at_relay_q <= at_q;
            at_oen_q <= at_q[1:0];
            od_level_q <= 1'b0;
            fo_en_q <= {4{~(suppress_en_in & major_cause)}};
            status_q <= status_d;
        end
    end
    assign major_lamp_out = major_q;
    assign major_relay_out = major_q;
    assign minor_lamp_out = minor_q;
    assign minor_relay_out = minor_q;
    assign satellite_tracking_lamp_out = trk_lamp_q;
    assign oscillator_locked_lamp_out = lock_lamp_q;
    assign at1_relay_out = at_relay_q[0];
    assign at2_relay_out = at_relay_q[1];
    assign at3_relay_out = at_relay_q[2];
    assign t1544_at1_relay_out = at_relay_q[0];
    assign dclk_at1_out = od_level_q;
    assign dclk_at2_out = od_level_q;
    assign dclk_at1_oen_out = at_oen_q[0];
    assign dclk_at2_oen_out = at_oen_q[1];
    assign freq_out_en_out = fo_en_q;
    assign alarm_status_out = status_q;

    // Checks on the block's outputs and internal state
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    logic [CNT_W-1:0] hi_cnt_q; // Front pulse high time, helper
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_q <= '0;
        end else begin
            hi_cnt_q <= pulse_q[0] ? hi_cnt_q + 1'b1 : '0;
        end
    end

    property p_pulse_width;
        hi_cnt_q <= CNT_W'(PULSE_CYCLES);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("front pulse too long");

    property p_pulse_fire;
        (pulse_fire[0] && !pulse_q[0]) |=> pulse_q[0] ##1 pulse_q[0];
    endproperty
    a_pulse_fire: assert property (p_pulse_fire) else $error("front pulse not at delay");

    property p_zero_delay;
        (rx_second_mark_in && fp_delay_in == '0 && !pulse_q[0]) |-> ##2 pulse_q[0];
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay pulse late");

    property p_major;
        major_cause |=> major_relay_out && major_lamp_out;
    endproperty
    a_major: assert property (p_major) else $error("major alarm missing");

    property p_no_latch;
        (!major_cause && !minor_cause) |=> !major_relay_out && !minor_relay_out;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("alarm latched");

    property p_track_clear;
        rx_tracking_in |=> !at_q[0] && !at_q[1] && !at_q[2] ##1 !at1_relay_out;
    endproperty
    a_track_clear: assert property (p_track_clear) else $error("timeout not cleared");

    property p_at2_lamp;
        at_q[1] |=> !oscillator_locked_lamp_out && major_relay_out;
    endproperty
    a_at2_lamp: assert property (p_at2_lamp) else $error("lock lamp lit on timeout");

    property p_no_track_lamp;
        !rx_tracking_in |=> !satellite_tracking_lamp_out;
    endproperty
    a_no_track_lamp: assert property (p_no_track_lamp) else $error("tracking lamp lit");

    property p_offset_hold;
        (offset_q && !offset_settled_in) |=> offset_q && minor_cause;
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset alarm dropped");

    property p_suppress;
        (suppress_en_in && major_cause) |=> freq_out_en_out == 4'h0 && major_relay_out;
    endproperty
    a_suppress: assert property (p_suppress) else $error("outputs not suppressed");

    property p_open_drain;
        at_q[0] |=> dclk_at1_oen_out && !dclk_at1_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("status line not released");

    c_pulse: cover property ($rose(fp_second_pulse_out));
    c_at1: cover property ($rose(at_q[0]));
    c_major: cover property ($rose(major_relay_out));
    c_low_rate: cover property (dclk_low_rate_sel_in && $rose(dclk_low_rate_out));
endmodule

// file: dv/gtas_far_monitor.sv
// Far-side monitor: pulse widths and pulled-up timeout status lines
`timescale 1ns/1ps
module gtas_far_monitor (
    input wire logic clk_in,
    input wire logic pulse_in,
    input wire logic clk_1544k_in,
    input wire logic at1_in,
    input wire logic at1_oen_in,
    input wire logic at2_in,
    input wire logic at2_oen_in,
    output int pulse_width_out,
    output int k_high_out,
    output logic at1_line_out,
    output logic at2_line_out
);
    int pw_cnt = 0; // Running high count of the pulse
    int k_cnt = 0; // Running high count of 1544 kHz
    // Released line floats up through our pull-up
    assign at1_line_out = at1_oen_in ? 1'b1 : at1_in;
    assign at2_line_out = at2_oen_in ? 1'b1 : at2_in;
    // Widths latch when the watched signal falls
    always @(posedge clk_in) begin
        pw_cnt <= pulse_in ? pw_cnt + 1 : 0;
        if (!pulse_in && pw_cnt != 0) begin
            pulse_width_out <= pw_cnt;
        end
        k_cnt <= clk_1544k_in ? k_cnt + 1 : 0;
        if (!clk_1544k_in && k_cnt != 0) begin
            k_high_out <= k_cnt;
        end
    end
endmodule

// file: dv/gtas_top_tb.sv
// Self-checking bench for the timing outputs and alarm supervisor
`timescale 1ns/1ps
module gtas_top_tb;
    import gtas_pkg::*;
    localparam int SEC_N = 1000; // Short second keeps the run brief
    localparam int PULSE_N = 200; // 20 percent of the short second
    logic clk_in, resetn_in, mark, trk, disc, lrs, onew, oset, sup;
    logic [DELAY_W-1:0] fpd, dcd;
    logic [CNT_W-1:0] l1, l2, l3;
    logic [10:0] cause; // freq,cpu,test,free,gate,miss[3:0],near,batt
    logic fpp, k1544, dsp, d96, dlow, a1, a1oe, a2, a2oe, t1r, tl, ll;
    logic majl, minl, majr, minr, r1, r2, r3, ln1, ln2;
    logic [3:0] fen;
    logic [ST_W-1:0] st;
    int pw, kh, err_count = 0, checks_done = 0, cyc = 0, n0, n1;
    gtas_top #(.SEC_CYCLES(SEC_N), .PULSE_CYCLES(PULSE_N)) gtas_top_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .rx_second_mark_in(mark), .rx_tracking_in(trk),
        .osc_disciplined_in(disc), .fp_delay_in(fpd), .dclk_delay_in(dcd), .dclk_low_rate_sel_in(lrs),
        .first_tracking_timeout_limit_in(l1), .second_tracking_timeout_limit_in(l2),
        .third_tracking_timeout_limit_in(l3), .freq_error_in(cause[10]), .cpu_fault_in(cause[9]),
        .test_mode_in(cause[8]), .free_run_in(cause[7]), .short_gate_in(cause[6]),
        .output_missing_in(cause[5:2]), .osc_near_limit_in(cause[1]), .battery_fail_in(cause[0]),
        .offset_new_in(onew), .offset_settled_in(oset), .suppress_en_in(sup),
        .fp_second_pulse_out(fpp), .clk_1544k_out(k1544), .dclk_second_pulse_out(dsp),
        .dclk_9600_out(d96), .dclk_low_rate_out(dlow), .dclk_at1_out(a1), .dclk_at1_oen_out(a1oe),
        .dclk_at2_out(a2), .dclk_at2_oen_out(a2oe), .t1544_at1_relay_out(t1r),
        .satellite_tracking_lamp_out(tl), .oscillator_locked_lamp_out(ll), .major_lamp_out(majl),
        .minor_lamp_out(minl), .major_relay_out(majr), .minor_relay_out(minr), .at1_relay_out(r1),
        .at2_relay_out(r2), .at3_relay_out(r3), .freq_out_en_out(fen), .alarm_status_out(st));
    gtas_far_monitor gtas_far_monitor_inst (.clk_in(clk_in), .pulse_in(fpp), .clk_1544k_in(k1544),
        .at1_in(a1), .at1_oen_in(a1oe), .at2_in(a2), .at2_oen_in(a2oe), .pulse_width_out(pw),
        .k_high_out(kh), .at1_line_out(ln1), .at2_line_out(ln2));
    // Free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Verdict and end of run, shared by main flow and watchdog
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One comparison, reported at once on mismatch
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Edges then settle; reads happen at the falling edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Mark pulse, then count cycles until the chosen pulse rises
    task automatic mark_rise(input bit dc, output int n);
        // Look at settled outputs, then raise the mark on a rising edge
        @(negedge clk_in);
        while (fpp !== 1'b0 || dsp !== 1'b0) @(negedge clk_in);
        @(posedge clk_in);
        mark <= 1'b1;
        @(posedge clk_in);
        mark <= 1'b0;
        n = 0;
        while ((dc ? dsp : fpp) !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
    endtask
    // Watchdog: whole run needs about 4k cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        {mark, trk, disc, lrs, onew, oset, sup} = 7'h20; // Tracking keeps timeouts quiet early on
        fpd = '0;
        dcd = '0;
        cause = 11'h000;
        l1 = 27'h0000001; // Controller programs short timeouts
        l2 = 27'h0000002;
        l3 = 27'h0000003;
        resetn_in = 1'b0;
        step(16);
        resetn_in <= 1'b1;
        step(4);
        // Second pulse timing against the mark
        mark_rise(1'b0, n0);
        chk("fp_zero_delay_rise", 1, n0 <= 13);
        step(300);
        chk("fp_width", PULSE_N, pw);
        chk("clk_1544k_high", 1, kh >= 31 && kh <= 34);
        fpd <= 24'h000005;
        dcd <= 24'h000003;
        step(2);
        mark_rise(1'b0, n1);
        chk("fp_delay_cycles", 50, n1 - n0);
        mark_rise(1'b1, n1);
        chk("dclk_delay_cycles", 30, n1 - n0);
        $display("Test pulses done");
        // Each of the eleven direct fault inputs alone, with suppression on
        step(1);
        sup <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            cause <= 11'h001 << i;
            step(3);
            @(negedge clk_in);
            chk("major_lamp", i >= 6, majl);
            chk("major_relay", i >= 6, majr);
            chk("minor_lamp", i <= 5 || i == 8, minl);
            chk("minor_relay", i <= 5 || i == 8, minr);
            chk("status_major", i >= 6, st[ST_MAJOR]);
            chk("freq_out_en", (i >= 6) ? 4'h0 : 4'hF, fen);
            chk("status_minor", i <= 5 || i == 8, st[ST_MINOR]);
            step(1);
            cause <= 11'h000;
            step(3);
            @(negedge clk_in);
            chk("alarms_released", 0, {majr, minr, majl, minl});
            chk("outputs_restored", 4'hF, fen);
            step(1);
        end
        sup <= 1'b0;
        $display("Test alarm causes done");
        // Offset alarm holds until correction completes
        onew <= 1'b1;
        step(1);
        onew <= 1'b0;
        step(12);
        @(negedge clk_in);
        chk("offset_held", 1, minr);
        chk("offset_status", 1, st[ST_OFFSET]);
        step(1);
        oset <= 1'b1;
        step(1);
        oset <= 1'b0;
        step(3);
        @(negedge clk_in);
        chk("offset_cleared", 0, minr);
        $display("Test offset done");
        // Lamps while tracking, then the three timeouts
        step(1);
        trk <= 1'b1;
        disc <= 1'b1;
        step(4);
        @(negedge clk_in);
        chk("tracking_lamp", 1, tl);
        chk("locked_lamp", 1, ll);
        chk("status_lines_low", 0, {ln1, ln2});
        chk("status_track_disc", 2'h3, {st[ST_TRACKING], st[ST_DISCIPLINED]});
        step(1);
        trk <= 1'b0;
        step(3);
        @(negedge clk_in);
        chk("tracking_lamp_off", 0, tl);
        n0 = 0;
        while (r1 !== 1'b1 && n0 < 2500) begin
            @(negedge clk_in);
            n0++;
        end
        chk("at1_relay", 1, r1);
        chk("at1_minor", 1, minl);
        chk("at2_not_yet", 0, r2);
        chk("at1_connectors", 3'h7, {t1r, a1oe, ln1});
        while (r2 !== 1'b1 && n0 < 5000) begin
            @(negedge clk_in);
            n0++;
        end
        step(1);
        @(negedge clk_in);
        chk("at2_major_lamp_off", 3'h6, {r2, majl, ll});
        chk("at2_connector", 2'h3, {a2oe, ln2});
        while (r3 !== 1'b1 && n0 < 7500) begin
            @(negedge clk_in);
            n0++;
        end
        chk("at3_major", 2'h3, {r3, majr});
        chk("status_timeouts", 3'h7, {st[ST_AT1], st[ST_AT2], st[ST_AT3]});
        step(1);
        trk <= 1'b1;
        step(4);
        @(negedge clk_in);
        chk("timeouts_cleared", 0, {r1, r2, r3, t1r, a1oe, a2oe, majr, minr});
        chk("lamps_back", 2'h3, {tl, ll});
        $display("Test timeouts done");
        // Mid-run reset with the low-rate option; data clocks restart at the first second
        step(1);
        lrs <= 1'b1;
        resetn_in <= 1'b0;
        step(3);
        @(negedge clk_in);
        chk("reset_outputs", 0, {fpp, dsp, d96, dlow, majr, minr, tl, ll, r1, a1oe, st});
        chk("reset_enables", 4'hF, fen);
        step(1);
        resetn_in <= 1'b1;
        step(5);
        @(negedge clk_in);
        chk("clocks_restart", 2'h3, {d96, dlow});
        chk("lamps_after_reset", 2'h3, {tl, ll});
        $display("Test reset done");
        stop_test();
    end
endmodule
